// ### core/boot_watchdog_recovery.v
// boot watchdog with bootstrap cpu rotation, phase status and beep codes
// assumes a 20 MHz core clock, a plain register port from the same domain,
// and platform reset levels arriving asynchronously on pins; the hard reset
// pin is high while the platform holds the system in reset, and the soft
// reset pin is synchronised but never acts on the timer
//
// Functional notes
// - one countdown timer whose expiry may reset the system.
// - reset-recovery countdown starts on every release from hard reset while a cpu is left to try.
// - on recovery expiry pick next cpu and reset system, except after the last cpu, which ends the retries until rst.
// - cpu rotation restarts on rst only, not on a system reset.
// - soft reset changes neither running state nor count of recovery countdown.
// - beep codes on the speaker when no working cpu is found.
// - never disable a failed cpu; log recovery failure without firmware.
// - sticky status shows early self-test, late self-test or OS load expiry.
// - OS load expiry resets the system only under the reset policy.
// - default OS expiry does nothing; policy may pick reset or power-off.
//
// The implementer's own choices: the address map and the strobed register port.
`include "boot_wdog_regs.vh"
`default_nettype none

module boot_watchdog_recovery #(
   parameter NUM_CPUS = 2,
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter BEEPS = 3
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // platform reset levels from pins
   input wire hard_reset_pin,
   input wire soft_reset_pin,
   // register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [31:0] reg_rdata,
   // system actions
   output reg sys_reset_req,
   output reg power_off_req,
   output reg [NUM_CPUS-1:0] bootstrap_cpu_sel,
   output reg speaker,
   output reg expiry_event,
   output reg log_valid,
   output reg [7:0] log_data
);

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   wire [1:0] pins_sync;
   reg hard_prev;

   pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({soft_reset_pin, hard_reset_pin}),
      .sync_out(pins_sync)
   );

   wire hard_in = pins_sync[0];
   // a falling hard reset level marks the system leaving hard reset
   wire hard_release = hard_prev && !hard_in;

   // cleared by rst like the synchroniser, so no false release follows rst
   always @(posedge core_clk) begin
      if (rst) begin
         hard_prev <= 1'b0;
      end else begin
         hard_prev <= hard_in;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   reg arm;
   reg [1:0] phase;
   reg [1:0] policy;
   reg [31:0] timeout;
   reg [31:0] count;
   reg [5:0] status;
   reg [31:0] tick_cnt;
   reg [7:0] tries;
   reg no_good_cpu;
   reg [15:0] rst_cnt;
   reg [7:0] last_event;

   wire wr_ctrl = reg_write && (reg_addr == `REG_CTRL);
   wire wr_timeout = reg_write && (reg_addr == `REG_TIMEOUT);
   wire wr_clear = reg_write && (reg_addr == `REG_CLEAR);
   wire tick = (tick_cnt == TICK_CYCLES - 1);
   wire expire = arm && tick && (count == 32'h0000_0001);

   // system reset pulse length less one, cut to the width of its counter
   localparam integer RST_HOLD = `SYS_RESET_CYCLES - 1;

   // ---------------------------------------------------------------
   // tick and countdown
   // ---------------------------------------------------------------
   // the tick phase runs free while armed, so the first tick after a rewrite
   // may come early; a timeout of zero wraps and expires only after 2^32 ticks
   always @(posedge core_clk) begin
      if (rst) begin
         tick_cnt <= 32'h0000_0000;
      end else if (!arm || tick) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // soft reset is not sampled here at all, so it cannot touch the timer
   always @(posedge core_clk) begin
      if (rst) begin
         arm <= 1'b0;
         phase <= `PHASE_RESET_RECOVERY;
         policy <= `POLICY_NONE;
         count <= 32'h0000_0000;
      end else if (hard_release && !no_good_cpu) begin
         arm <= 1'b1;
         phase <= `PHASE_RESET_RECOVERY;
         count <= timeout;
      end else if (wr_ctrl) begin
         // arming reloads the count, so a rewrite extends the timeout
         arm <= reg_wdata[`CTRL_ARM];
         phase <= reg_wdata[`CTRL_PHASE_HI:`CTRL_PHASE_LO];
         policy <= reg_wdata[`CTRL_POLICY_HI:`CTRL_POLICY_LO];
         count <= timeout;
      end else if (expire) begin
         arm <= 1'b0;
         count <= 32'h0000_0000;
      end else if (arm && tick) begin
         count <= count - 32'h0000_0001;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         timeout <= `TIMEOUT_RESET;
      end else if (wr_timeout) begin
         timeout <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // expiry actions
   // ---------------------------------------------------------------
   wire exp_recovery = expire && (phase == `PHASE_RESET_RECOVERY);
   wire exp_early = expire && (phase == `PHASE_EARLY_SELF_TEST);
   wire exp_late = expire && (phase == `PHASE_LATE_SELF_TEST);
   wire exp_os = expire && (phase == `PHASE_OS_LOAD);
   // operating system load expiry acts only as the policy asks
   wire os_reset = exp_os && (policy == `POLICY_RESET);
   wire os_power_off = exp_os && (policy == `POLICY_POWER_OFF);
   wire do_reset = exp_recovery || os_reset;
   // the last try is the one that rotates back to the first cpu
   wire last_try = (tries == NUM_CPUS - 1);

   // ---------------------------------------------------------------
   // bootstrap cpu rotation
   // ---------------------------------------------------------------
   wire [NUM_CPUS-1:0] next_cpu_sel;
   genvar gi;

   generate
      for (gi = 0; gi < NUM_CPUS; gi = gi + 1) begin : g_rot
         // each cpu takes over from the one below it, the lowest from the highest
         assign next_cpu_sel[gi] = bootstrap_cpu_sel[(gi + NUM_CPUS - 1) % NUM_CPUS];
      end
   endgenerate

   always @(posedge core_clk) begin
      if (rst) begin
         bootstrap_cpu_sel <= {{(NUM_CPUS-1){1'b0}}, 1'b1};
         tries <= 8'h00;
         no_good_cpu <= 1'b0;
      end else if (exp_recovery) begin
         // failed cpu stays enabled; only the boot choice rotates
         bootstrap_cpu_sel <= next_cpu_sel;
         if (last_try) begin
            no_good_cpu <= 1'b1;
         end else begin
            tries <= tries + 8'h01;
         end
      end
   end

   // ---------------------------------------------------------------
   // system reset and power-off requests
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         rst_cnt <= 16'h0000;
         sys_reset_req <= 1'b0;
      end else if (do_reset && !(exp_recovery && last_try)) begin
         rst_cnt <= RST_HOLD[15:0];
         sys_reset_req <= 1'b1;
      end else if (rst_cnt != 16'h0000) begin
         rst_cnt <= rst_cnt - 16'h0001;
      end else begin
         sys_reset_req <= 1'b0;
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         power_off_req <= 1'b0;
      end else if (os_power_off) begin
         power_off_req <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // expiry event, log and sticky status
   // ---------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         expiry_event <= 1'b0;
         log_valid <= 1'b0;
         log_data <= 8'h00;
         last_event <= 8'h00;
      end else begin
         expiry_event <= expire;
         log_valid <= exp_recovery;
         if (exp_recovery) begin
            log_data <= {tries[5:0], 2'h0};
            last_event <= {tries[5:0], 2'h0};
         end
      end
   end

   // sticky status: set wins over a clear in the same cycle
   wire [5:0] set_bits = {1'b0, (exp_recovery && last_try), exp_recovery,
                          exp_os, exp_late, exp_early};

   always @(posedge core_clk) begin
      if (rst) begin
         status <= 6'h00;
      end else begin
         status <= (status & ~(wr_clear ? reg_wdata[5:0] : 6'h00)) | set_bits;
      end
   end

   // ---------------------------------------------------------------
   // speaker
   // ---------------------------------------------------------------
   wire beep_wire;

   beep_gen #(
      .HALF_CYCLES(`BEEP_HALF_CYCLES),
      .BEEPS(BEEPS)
   ) u_beep (
      .core_clk(core_clk),
      .rst(rst),
      .enable(no_good_cpu),
      .speaker(beep_wire)
   );

   always @(posedge core_clk) begin
      if (rst) begin
         speaker <= 1'b0;
      end else begin
         speaker <= beep_wire;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   // answers one cycle after the strobe and returns zero otherwise
   always @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         case (reg_addr)
            `REG_CTRL: reg_rdata <= {27'h0, policy, phase, arm};
            `REG_TIMEOUT: reg_rdata <= timeout;
            `REG_COUNT: reg_rdata <= count;
            `REG_STATUS: reg_rdata <= {26'h0, arm, no_good_cpu, status[3:0]};
            `REG_EVENT: reg_rdata <= {24'h0, last_event};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // boot_watchdog_recovery

`default_nettype wire

// ### core/boot_wdog_regs.vh
// boot watchdog register map, field positions, reset values and timing counts
// assumes a 20 MHz core clock and a word-wide plain register port
`ifndef BOOT_WDOG_REGS_VH
`define BOOT_WDOG_REGS_VH

// register offsets (word index on the plain port)
`define REG_CTRL 4'h0
`define REG_TIMEOUT 4'h1
`define REG_COUNT 4'h2
`define REG_STATUS 4'h3
`define REG_CLEAR 4'h4
`define REG_EVENT 4'h5

// control fields
`define CTRL_ARM 0
`define CTRL_PHASE_LO 1
`define CTRL_PHASE_HI 2
`define CTRL_POLICY_LO 3
`define CTRL_POLICY_HI 4

// phase codes carried in the control word
`define PHASE_RESET_RECOVERY 2'h0
`define PHASE_EARLY_SELF_TEST 2'h1
`define PHASE_LATE_SELF_TEST 2'h2
`define PHASE_OS_LOAD 2'h3

// policy for an expiry in operating system load supervision
`define POLICY_NONE 2'h0
`define POLICY_RESET 2'h1
`define POLICY_POWER_OFF 2'h2

// status fields
`define ST_EXP_EARLY 0
`define ST_EXP_LATE 1
`define ST_EXP_OS 2
`define ST_EXP_RECOVERY 3
`define ST_NO_GOOD_CPU 4
`define ST_RUNNING 5

// reset values
`define TIMEOUT_RESET 32'h0000_0064
`define CTRL_RESET 8'h00

// tick of 100 ms derived from the core clock
`define CLK_HZ 20000000
`define TICK_MS 100
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)

// system reset pulse length and beep half period
`define SYS_RESET_US 100
`define SYS_RESET_CYCLES ((`CLK_HZ / 1000000) * `SYS_RESET_US)
`define BEEP_HALF_US 500
`define BEEP_HALF_CYCLES ((`CLK_HZ / 1000000) * `BEEP_HALF_US)

`endif

// ### core/pin_sync.v
// two-stage synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk
`default_nettype none

module pin_sync #(
   parameter WIDTH = 2
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // levels
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] stage1;

   always @(posedge core_clk) begin
      if (rst) begin
         stage1 <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // pin_sync

`default_nettype wire

// ### core/beep_gen.v
// speaker tone with on/off beep groups while enabled
// assumes a free-running core clock
`default_nettype none

module beep_gen #(
   parameter HALF_CYCLES = 10000,
   parameter BEEPS = 3
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // control
   input wire enable,
   output reg speaker
);

   reg [15:0] half_cnt;
   reg [7:0] cycle_cnt;
   reg [3:0] beep_cnt;
   reg tone_on;

   always @(posedge core_clk) begin
      if (rst || !enable) begin
         half_cnt <= 16'h0000;
         cycle_cnt <= 8'h00;
         beep_cnt <= 4'h0;
         tone_on <= 1'b1;
         speaker <= 1'b0;
      end else if (half_cnt == HALF_CYCLES[15:0] - 16'h0001) begin
         half_cnt <= 16'h0000;
         speaker <= tone_on ? ~speaker : 1'b0;
         if (cycle_cnt == 8'hFF) begin
            // about 128 ms per tone or gap slot
            cycle_cnt <= 8'h00;
            tone_on <= ~tone_on;
            if (!tone_on) begin
               if (beep_cnt == BEEPS[3:0])
                  beep_cnt <= 4'h0;
               else
                  beep_cnt <= beep_cnt + 4'h1;
            end
            if (beep_cnt == BEEPS[3:0])
               tone_on <= 1'b0;
         end else begin
            cycle_cnt <= cycle_cnt + 8'h01;
         end
      end else begin
         half_cnt <= half_cnt + 16'h0001;
      end
   end

endmodule // beep_gen

`default_nettype wire

// ### testbench/platform_model.sv
// platform model: turns reset and boot requests into hard reset, makes soft resets
// assumes the core clock of the watchdog and level pins sampled by it
`default_nettype none
module platform_model (
   // clock
   input wire logic core_clk,
   // requests
   input wire logic sys_reset_req,
   input wire logic power_cmd,
   input wire logic soft_cmd,
   // pins
   output logic hard_reset_pin,
   output logic soft_reset_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] stretch = 3'h0;
   initial hard_reset_pin = 1'b0;
   initial soft_reset_pin = 1'b0;
   // hard reset is held a few cycles past the request
   always @(posedge core_clk) begin
      if (sys_reset_req || power_cmd) stretch <= 3'h4;
      else if (stretch != 3'h0) stretch <= stretch - 3'h1;
      hard_reset_pin <= sys_reset_req || power_cmd || stretch != 3'h0;
      soft_reset_pin <= soft_cmd && !soft_reset_pin;
   end
endmodule // platform_model
`default_nettype wire

// ### testbench/boot_wdog_checker.sv
// port-level timing checks of the boot watchdog
// assumes a bind onto boot_watchdog_recovery, one clock domain
`default_nettype none
module boot_wdog_checker #(
   parameter NUM_CPUS = 2
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // observed ports
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic sys_reset_req,
   input wire logic power_off_req,
   input wire logic [NUM_CPUS-1:0] bootstrap_cpu_sel,
   input wire logic expiry_event,
   input wire logic log_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] pulse_len;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // length of the current system reset pulse
   always @(posedge core_clk) begin
      if (rst || !sys_reset_req) pulse_len <= 12'h000;
      else pulse_len <= pulse_len + 12'h001;
   end
   sequence recent_expiry;
      expiry_event || $past(expiry_event) || $past(expiry_event, 2);
   endsequence
   expiry_pulse_a: assert property (expiry_event |=> !expiry_event)
      else $error("expiry event longer than one cycle");
   log_pulse_a: assert property (log_valid |=> !log_valid)
      else $error("log strobe longer than one cycle");
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside the answer cycle");
   cpu_onehot_a: assert property ($onehot(bootstrap_cpu_sel))
      else $error("cpu select not one-hot");
   cpu_restart_a: assert property (disable iff (1'b0) rst |=> bootstrap_cpu_sel == 1)
      else $error("cpu rotation not restarted");
   reset_len_a: assert property ($fell(sys_reset_req) |-> pulse_len == 12'h7D0)
      else $error("system reset pulse length wrong");
   reset_cause_a: assert property ($rose(sys_reset_req) |-> recent_expiry)
      else $error("system reset without expiry");
   power_hold_a: assert property (power_off_req |=> power_off_req)
      else $error("power off request dropped");
endmodule // boot_wdog_checker
`default_nettype wire

// ### testbench/boot_watchdog_recovery_tb.sv
// self-checking bench of the boot watchdog with a platform model
// assumes the design under core/ and its register header on the include path
`include "boot_wdog_regs.vh"
`default_nettype none
module boot_watchdog_recovery_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic power_cmd = 1'b0;
   logic soft_cmd = 1'b0;
   logic hard_reset_pin, soft_reset_pin, sys_reset_req, power_off_req, speaker;
   logic expiry_event, log_valid;
   logic [31:0] reg_rdata;
   logic [1:0] bootstrap_cpu_sel;
   logic [7:0] log_data;
   int num_errors = 0;
   int n_checks = 0;
   boot_watchdog_recovery #(.NUM_CPUS(2), .TICK_CYCLES(10)) i_dut (
      .core_clk(core_clk), .rst(rst), .hard_reset_pin(hard_reset_pin),
      .soft_reset_pin(soft_reset_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .sys_reset_req(sys_reset_req), .power_off_req(power_off_req),
      .bootstrap_cpu_sel(bootstrap_cpu_sel), .speaker(speaker),
      .expiry_event(expiry_event), .log_valid(log_valid), .log_data(log_data));
   platform_model i_platform (.core_clk(core_clk), .sys_reset_req(sys_reset_req),
      .power_cmd(power_cmd), .soft_cmd(soft_cmd), .hard_reset_pin(hard_reset_pin),
      .soft_reset_pin(soft_reset_pin));
   // ----------------------------------------
   // bus and helper tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk); reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
      @(posedge core_clk); reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk); reg_addr <= a; reg_read <= 1'b1;
      @(posedge core_clk); reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_exp(input int lim, output int n);
      n = 0;
      do begin @(posedge core_clk); #1; n++; end while (expiry_event !== 1'b1 && n < lim);
   endtask
   task automatic boot();
      @(posedge core_clk); power_cmd <= 1'b1;
      repeat (2) @(posedge core_clk);
      power_cmd <= 1'b0;
   endtask
   task automatic do_reset();
      @(posedge core_clk); rst <= 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      logic [31:0] d;
      chk("cpu select", 1, bootstrap_cpu_sel);
      chk("outputs", 0, {sys_reset_req, power_off_req, speaker, expiry_event});
      rd(`REG_TIMEOUT, d); chk("timeout reset", `TIMEOUT_RESET, d);
      rd(4'hF, d); chk("unmapped read", 0, d);
      wr(`REG_STATUS, 32'hFFFF_FFFF); rd(`REG_STATUS, d); chk("status ro", 0, d);
   endtask
   task automatic t_recovery();
      logic [31:0] d; int n; int tog; logic prev;
      wr(`REG_TIMEOUT, 32'h0000_0003); boot(); wait_exp(80, n);
      chk("recovery time", 1, n >= 20 && n <= 50);
      chk("first log entry", 32'h100, {log_valid, log_data});
      repeat (3) @(posedge core_clk);
      #1 chk("reset request", 1, sys_reset_req);
      chk("next cpu", 2, bootstrap_cpu_sel);
      wait_exp(2200, n); chk("second expiry", 1, expiry_event);
      chk("second log entry", 32'h104, {log_valid, log_data});
      repeat (3) @(posedge core_clk);
      #1 chk("no reset", 0, sys_reset_req);
      rd(`REG_STATUS, d); chk("fail status", 32'h18, d & 32'h38);
      rd(`REG_EVENT, d); chk("event log", 1, d != 0 && d[1:0] == 2'h0);
      tog = 0; prev = speaker;
      repeat (25000) begin @(posedge core_clk); #1; if (speaker !== prev) tog++; prev = speaker; end
      chk("speaker", 1, tog > 0);
      do_reset();
      #1 chk("rotation restart", 1, bootstrap_cpu_sel);
      chk("speaker quiet", 0, speaker);
   endtask
   task automatic t_disable();
      logic [31:0] d; int n;
      wr(`REG_TIMEOUT, 32'h0000_0003); boot();
      repeat (12) @(posedge core_clk);
      rd(`REG_STATUS, d); chk("running", 32'h20, d);
      wr(`REG_CTRL, {27'h0, 2'h0, `PHASE_EARLY_SELF_TEST, 1'b1});
      wr(`REG_CTRL, 32'h0000_0000);
      wait_exp(80, n); chk("disabled", 0, expiry_event);
   endtask
   task automatic t_soft();
      int n;
      wr(`REG_TIMEOUT, 32'h0000_0003); boot(); soft_cmd <= 1'b1; wait_exp(80, n);
      @(posedge core_clk); soft_cmd <= 1'b0;
      chk("soft reset", 1, n >= 20 && n <= 50);
   endtask
   task automatic t_os_load();
      logic [31:0] d; int n;
      do_reset();
      wr(`REG_TIMEOUT, 32'h0000_0004);
      wr(`REG_CTRL, {27'h0, 2'h0, `PHASE_LATE_SELF_TEST, 1'b1});
      repeat (25) @(posedge core_clk);
      wr(`REG_CTRL, {27'h0, 2'h0, `PHASE_LATE_SELF_TEST, 1'b1});
      wait_exp(80, n); chk("extended time", 1, n >= 25 && n <= 45);
      wr(`REG_TIMEOUT, 32'h0000_0BB8);
      wr(`REG_CTRL, {27'h0, `POLICY_RESET, `PHASE_OS_LOAD, 1'b1});
      rd(`REG_COUNT, d); chk("os count", 1, d >= 32'hBB6 && d <= 32'hBB8);
      wr(`REG_CTRL, 32'h0000_0000);
      wait_exp(40, n); chk("os disabled", 0, expiry_event);
      rd(`REG_STATUS, d); chk("sticky status", 32'h2, d);
   endtask
   task automatic t_phase(input logic [1:0] ph, input logic [1:0] pol);
      logic [31:0] d; int n;
      do_reset();
      wr(`REG_TIMEOUT, 32'h0000_0002); wr(`REG_CTRL, {27'h0, pol, ph, 1'b1});
      wait_exp(60, n); chk("phase time", 1, n >= 10 && n <= 30);
      repeat (3) @(posedge core_clk);
      #1 if (ph == `PHASE_OS_LOAD) begin
         chk("os reset", pol == `POLICY_RESET, sys_reset_req);
         chk("power off", pol == `POLICY_POWER_OFF, power_off_req);
      end
      rd(`REG_STATUS, d); chk("phase status", 32'h1 << (ph - 1), d & 32'h7);
      wr(`REG_CLEAR, 32'h0000_000F);
      rd(`REG_STATUS, d); chk("status clear", 0, d & 32'hF);
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial forever #25 core_clk = ~core_clk;
   initial begin
      #3000000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_reset_values();
      t_recovery();
      t_disable();
      t_soft();
      t_os_load();
      t_phase(`PHASE_EARLY_SELF_TEST, `POLICY_NONE);
      t_phase(`PHASE_LATE_SELF_TEST, `POLICY_NONE);
      t_phase(`PHASE_OS_LOAD, `POLICY_NONE);
      t_phase(`PHASE_OS_LOAD, `POLICY_RESET);
      t_phase(`PHASE_OS_LOAD, `POLICY_POWER_OFF);
      close_out();
   end
endmodule // boot_watchdog_recovery_tb
bind boot_watchdog_recovery boot_wdog_checker #(.NUM_CPUS(NUM_CPUS)) i_chk (
   .core_clk(core_clk), .rst(rst), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .sys_reset_req(sys_reset_req), .power_off_req(power_off_req),
   .bootstrap_cpu_sel(bootstrap_cpu_sel), .expiry_event(expiry_event),
   .log_valid(log_valid));
`default_nettype wire
